// ---- hw/fcp_pkg.sv ----
// shared constants and types of the flash code-protect and configuration block
package fcp_pkg;
	localparam int ADDR_W        = 14;
	localparam int WORD_W        = 14;
	localparam int DM_W          = 8;
	localparam int PM_DEPTH      = 1024;
	localparam int PM_IDX_W      = 10;
	localparam int DM_DEPTH      = 64;
	localparam int DM_IDX_W      = 6;
	localparam int ID_COUNT      = 4;
	localparam int ID_IDX_W      = 2;
	localparam int CP_W          = 10;
	localparam int FRAME_W       = 16;
	localparam int CNT_W         = 5;
	// address map of the programming space
	localparam logic [13:0] CFG_SPACE_ADDR = 14'h2000;
	localparam logic [13:0] ID_LAST_ADDR   = 14'h2003;
	localparam logic [13:0] CFG_WORD_ADDR  = 14'h2007;
	// blank, masked and reset values
	localparam logic [13:0] CFG_ERASED     = 14'h3FFF;
	localparam logic [13:0] PM_BLANK       = 14'h3FFF;
	localparam logic [13:0] PM_MASKED      = 14'h0000;
	localparam logic [13:0] UNIMPL_READ    = 14'h0000;
	localparam logic [7:0]  DM_BLANK       = 8'hFF;
	localparam logic [7:0]  DM_MASKED_ROM  = 8'hFF;
	localparam logic [7:0]  DM_MASKED_EE   = 8'h00;
	localparam logic [9:0]  CP_ALL_OFF     = 10'h3FF;
	localparam logic [9:0]  CP_ALL_ON      = 10'h000;
	// serial frame layout: six command bits, sixteen data bits, lsb first
	localparam logic [4:0]  CMD_LAST_BIT   = 5'h05;
	localparam logic [4:0]  FRAME_LAST_BIT = 5'h0F;
	localparam int          CMD_LSB        = 10;
	localparam int          PAYLOAD_LSB    = 1;
	// six-bit commands
	localparam logic [5:0]  CMD_LOAD_CFG   = 6'h00;
	localparam logic [5:0]  CMD_ERASE_A    = 6'h01;
	localparam logic [5:0]  CMD_LOAD_PM    = 6'h02;
	localparam logic [5:0]  CMD_LOAD_DM    = 6'h03;
	localparam logic [5:0]  CMD_READ_PM    = 6'h04;
	localparam logic [5:0]  CMD_READ_DM    = 6'h05;
	localparam logic [5:0]  CMD_INC_ADDR   = 6'h06;
	localparam logic [5:0]  CMD_ERASE_B    = 6'h07;
	localparam logic [5:0]  CMD_BEGIN_PROG = 6'h08;
	// programming wait seen by the programmer
	localparam int          PROG_WAIT_NS   = 10000000;
	localparam int          CLK_PERIOD_NS  = 4;
	localparam int          PROG_WAIT_CYC  = PROG_WAIT_NS / CLK_PERIOD_NS;
	localparam int          BUSY_W         = 22;

	typedef enum logic [1:0] {
		FCP_RX_CMD  = 2'b00,
		FCP_RX_LOAD = 2'b01,
		FCP_TX_READ = 2'b10
	} fcp_ser_e;

	typedef enum logic [1:0] {
		FCP_SEQ_IDLE  = 2'b00,
		FCP_SEQ_HALF  = 2'b01,
		FCP_SEQ_ARMED = 2'b10
	} fcp_seq_e;

	typedef enum logic [1:0] {
		FCP_LOW_POWER_CRYSTAL_OSC = 2'b00,
		FCP_STANDARD_CRYSTAL_OSC  = 2'b01,
		FCP_HIGH_SPEED_CRYSTAL_OSC = 2'b10,
		FCP_RESISTOR_CAPACITOR_OSC = 2'b11
	} fcp_osc_e;

	typedef struct packed {
		logic [9:0] codeProtectBits;
		logic       powerupDelayEnable;
		logic       watchdogEnableBit;
		fcp_osc_e   oscillatorSelectField;
	} fcp_cfg_s;
endpackage

// ---- hw/fcp_config_protect.sv ----
// serial program/verify slave with code-protect masking and configuration word
`timescale 1ns/10ps
module fcp_config_protect
	import fcp_pkg::*;
#(
	parameter bit MASK_VARIANT      = 1'b0,          // 1: mask-programmed part
	parameter int PROG_WAIT_CYCLES  = PROG_WAIT_CYC  // begin-programming busy time
) (
	input  wire logic     mclk,            // system clock, 250 MHz
	input  wire logic     arst_n,          // asynchronous reset, active low
	input  wire logic     pgmClk,          // serial clock pin from programmer
	input  wire logic     pgmDataIn,       // serial data pin, input side
	output logic          pgmDataOut,      // serial data pin, output side
	output logic          pgmDataOe_n,     // low while the device drives data
	output logic          codeProtected,   // protection currently in force
	output fcp_cfg_s      cfgWord,         // live configuration word fields
	output logic          progBusy         // programming cycle in progress
);
	logic [1:0]          clkSync_r, datSync_r;
	logic                clkPrev_r;
	fcp_ser_e            state_r, state_nxt;
	fcp_seq_e            seq_r, seq_nxt;
	logic [CNT_W-1:0]    bitCnt_r, bitCnt_nxt;
	logic [FRAME_W-1:0]  shift_r, shift_nxt, txShift_r, tx_nxt;
	logic [5:0]          cmd_r, cmd_nxt, cmdWord;
	logic [ADDR_W-1:0]   addr_r, addr_nxt, loadBuf_r, loadBuf_nxt;
	logic                loadDm_r, loadDm_nxt, dout_nxt, oeN_nxt;
	logic [BUSY_W-1:0]   busy_r, busy_nxt;
	fcp_cfg_s            cfg_r, cfg_nxt;
	logic [WORD_W-1:0]   pmMem_r [PM_DEPTH];
	logic [WORD_W-1:0]   idMem_r [ID_COUNT];
	logic [DM_W-1:0]     dmMem_r [DM_DEPTH];
	logic                clkFall, clkRise, cmdDone, beginCmd, eraseAll;
	logic                inPm, isId, isCfg, prot, pmWe, dmWe, idWe;
	logic [WORD_W-1:0]   rdPm, pmCur;
	logic [DM_W-1:0]     rdDm;
	logic [PM_IDX_W-1:0] pmIdx;
	logic [DM_IDX_W-1:0] dmIdx;
	logic [ID_IDX_W-1:0] idIdx;

	// pins are asynchronous to mclk, two flops before anything looks at them
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			clkSync_r <= 2'h0;
			datSync_r <= 2'h0;
			clkPrev_r <= 1'b0;
		end else begin
			clkSync_r <= {clkSync_r[0], pgmClk};
			datSync_r <= {datSync_r[0], pgmDataIn};
			clkPrev_r <= clkSync_r[1];
		end
	end
	assign clkFall = clkPrev_r & ~clkSync_r[1];
	assign clkRise = ~clkPrev_r & clkSync_r[1];

	// address decode and protection state
	assign inPm  = addr_r < CFG_SPACE_ADDR;
	assign isId  = (addr_r >= CFG_SPACE_ADDR) && (addr_r <= ID_LAST_ADDR);
	assign isCfg = addr_r == CFG_WORD_ADDR;
	assign pmIdx = addr_r[PM_IDX_W-1:0];   // program space aliases above the array
	assign dmIdx = addr_r[DM_IDX_W-1:0];
	assign idIdx = addr_r[ID_IDX_W-1:0];
	assign pmCur = pmMem_r[pmIdx];
	// erasable parts protect on any zero; mask parts only on an all-zero field
	assign prot  = MASK_VARIANT ? (cfg_r.codeProtectBits == CP_ALL_ON)
	                            : (cfg_r.codeProtectBits != CP_ALL_OFF);

	// read values: program words masked, ids and configuration always true
	assign rdPm = inPm  ? (prot ? PM_MASKED : pmCur)
	            : isId  ? idMem_r[idIdx]
	            : isCfg ? WORD_W'(cfg_r)
	            : UNIMPL_READ;
	// protected data reads show a fixed fill, never the stored byte
	assign rdDm = !prot ? dmMem_r[dmIdx]
	            : (MASK_VARIANT ? DM_MASKED_ROM : DM_MASKED_EE);

	// serial engine: command decode, load frames, read frames
	always_comb begin
		state_nxt   = state_r;
		seq_nxt     = seq_r;
		bitCnt_nxt  = bitCnt_r;
		shift_nxt   = shift_r;
		tx_nxt      = txShift_r;
		cmd_nxt     = cmd_r;
		addr_nxt    = addr_r;
		loadBuf_nxt = loadBuf_r;
		loadDm_nxt  = loadDm_r;
		dout_nxt    = pgmDataOut;
		oeN_nxt     = pgmDataOe_n;
		cfg_nxt     = cfg_r;
		busy_nxt    = (busy_r != '0) ? busy_r - 1'b1 : busy_r;
		cmdDone     = 1'b0;
		pmWe        = 1'b0;
		dmWe        = 1'b0;
		idWe        = 1'b0;
		eraseAll    = 1'b0;
		if (clkFall) begin
			shift_nxt = {datSync_r[1], shift_r[FRAME_W-1:1]};
		end
		cmdWord  = shift_nxt[CMD_LSB +: 6];
		beginCmd = 1'b0;
		unique case (state_r)
			FCP_RX_CMD: begin
				if (clkFall) begin
					if (bitCnt_r == CMD_LAST_BIT) begin
						cmdDone    = 1'b1;
						bitCnt_nxt = '0;
						cmd_nxt    = cmdWord;
					end else begin
						bitCnt_nxt = bitCnt_r + 1'b1;
					end
				end
			end
			FCP_RX_LOAD: begin
				if (clkFall) begin
					if (bitCnt_r == FRAME_LAST_BIT) begin
						bitCnt_nxt  = '0;
						state_nxt   = FCP_RX_CMD;
						loadBuf_nxt = shift_nxt[PAYLOAD_LSB +: WORD_W];
						loadDm_nxt  = cmd_r == CMD_LOAD_DM;
						if (cmd_r == CMD_LOAD_CFG) begin
							addr_nxt = CFG_SPACE_ADDR;
						end
					end else begin
						bitCnt_nxt = bitCnt_r + 1'b1;
					end
				end
			end
			FCP_TX_READ: begin
				// data changes on the rising pin edge, programmer samples on the fall
				if (clkRise) begin
					dout_nxt = txShift_r[0];
					tx_nxt   = {1'b0, txShift_r[FRAME_W-1:1]};
					oeN_nxt  = 1'b0;
				end
				if (clkFall) begin
					if (bitCnt_r == FRAME_LAST_BIT) begin
						bitCnt_nxt = '0;
						state_nxt  = FCP_RX_CMD;
						oeN_nxt    = 1'b1;
					end else begin
						bitCnt_nxt = bitCnt_r + 1'b1;
					end
				end
			end
			default: begin
				state_nxt = FCP_RX_CMD;
			end
		endcase
		if (cmdDone) begin
			// the clear needs 000001 at the configuration word, then 000111 at once
			seq_nxt = FCP_SEQ_IDLE;
			if (cmdWord == CMD_ERASE_A && isCfg) begin
				seq_nxt = FCP_SEQ_HALF;
			end
			if (cmdWord == CMD_ERASE_B && seq_r == FCP_SEQ_HALF) begin
				seq_nxt = FCP_SEQ_ARMED;
			end
			if (cmdWord == CMD_LOAD_CFG || cmdWord == CMD_LOAD_PM || cmdWord == CMD_LOAD_DM) begin
				state_nxt = FCP_RX_LOAD;
			end
			if (cmdWord == CMD_READ_PM) begin
				state_nxt = FCP_TX_READ;
				tx_nxt    = {1'b0, rdPm, 1'b0};
			end
			if (cmdWord == CMD_READ_DM) begin
				state_nxt = FCP_TX_READ;
				tx_nxt    = {1'b0, {(WORD_W-DM_W){1'b0}}, rdDm, 1'b0};
			end
			if (cmdWord == CMD_INC_ADDR) begin
				addr_nxt = addr_r + 1'b1;
			end
			beginCmd = cmdWord == CMD_BEGIN_PROG;
		end
		if (beginCmd) begin
			busy_nxt = BUSY_W'(PROG_WAIT_CYCLES);
			if (seq_r == FCP_SEQ_ARMED && !MASK_VARIANT) begin
				// wipe program and data memory in the same cycle that lifts protection, so no code leaks out
				eraseAll = 1'b1;
				cfg_nxt  = CFG_ERASED;
			end else if (loadDm_r) begin
				// data bytes take the low address bits wherever the address points
				dmWe = !prot;
			end else if (!MASK_VARIANT) begin
				pmWe = inPm && !prot;
				idWe = isId;
				if (isCfg) begin
					cfg_nxt = loadBuf_r;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r     <= FCP_RX_CMD;
			seq_r       <= FCP_SEQ_IDLE;
			bitCnt_r    <= '0;
			shift_r     <= '0;
			txShift_r   <= '0;
			cmd_r       <= CMD_LOAD_CFG;
			addr_r      <= '0;
			loadBuf_r   <= '0;
			loadDm_r    <= 1'b0;
			pgmDataOut  <= 1'b0;
			pgmDataOe_n <= 1'b1;
			cfg_r       <= CFG_ERASED;
			busy_r      <= '0;
		end else begin
			state_r     <= state_nxt;
			seq_r       <= seq_nxt;
			bitCnt_r    <= bitCnt_nxt;
			shift_r     <= shift_nxt;
			txShift_r   <= tx_nxt;
			cmd_r       <= cmd_nxt;
			addr_r      <= addr_nxt;
			loadBuf_r   <= loadBuf_nxt;
			loadDm_r    <= loadDm_nxt;
			pgmDataOut  <= dout_nxt;
			pgmDataOe_n <= oeN_nxt;
			cfg_r       <= cfg_nxt;
			busy_r      <= busy_nxt;
		end
	end

	// storage is flip-flops; the erase reaches every program and data entry in the same cycle, the ids keep their values
	for (genvar g = 0; g < PM_DEPTH; g++) begin : g_mem
		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				pmMem_r[g] <= PM_BLANK;
			end else if (eraseAll) begin
				pmMem_r[g] <= PM_BLANK;
			end else if (pmWe && pmIdx == PM_IDX_W'(g)) begin
				pmMem_r[g] <= loadBuf_r;
			end
		end
		if (g < DM_DEPTH) begin : g_dm
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					dmMem_r[g] <= DM_BLANK;
				end else if (eraseAll) begin
					dmMem_r[g] <= DM_BLANK;
				end else if (dmWe && dmIdx == DM_IDX_W'(g)) begin
					dmMem_r[g] <= loadBuf_r[DM_W-1:0];
				end
			end
		end
		if (g < ID_COUNT) begin : g_id
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					idMem_r[g] <= PM_BLANK;
				end else if (idWe && idIdx == ID_IDX_W'(g)) begin
					idMem_r[g] <= loadBuf_r;
				end
			end
		end
	end

	// oscillator and watchdog fields drive the core straight from the word
	assign cfgWord       = cfg_r;
	assign codeProtected = prot;
	assign progBusy      = busy_r != '0;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	logic readPm, readDm;
	assign readPm = cmdDone && cmdWord == CMD_READ_PM;
	assign readDm = cmdDone && cmdWord == CMD_READ_DM;

	a_pm_read_mask: assert property (readPm && prot && inPm |=> txShift_r == '0)
		else $error("protected program read not zero");
	a_cfg_read_true: assert property (readPm && isCfg |=> txShift_r[14:1] == $past(cfg_r))
		else $error("configuration read masked");
	a_id_read_true: assert property (readPm && isId |=> txShift_r[14:1] == $past(idMem_r[idIdx]))
		else $error("id read wrong");
	a_pm_write_block: assert property (beginCmd && prot && inPm && !eraseAll |=> $stable(pmCur))
		else $error("protected program write accepted");
	a_cfg_write_open: assert property (beginCmd && isCfg && !MASK_VARIANT && !loadDm_r
		&& seq_r != FCP_SEQ_ARMED |=> cfg_r == $past(loadBuf_r))
		else $error("configuration write refused");
	a_pm_write_open: assert property (beginCmd && !prot && inPm && !MASK_VARIANT && !loadDm_r
		&& seq_r != FCP_SEQ_ARMED |=> pmCur == $past(loadBuf_r))
		else $error("unprotected write lost");
	a_mask_dm_ones: assert property (readDm && prot && MASK_VARIANT |=> txShift_r[8:1] == DM_MASKED_ROM)
		else $error("mask part data read not ones");
	a_erase_clears: assert property (beginCmd && seq_r == FCP_SEQ_ARMED && !MASK_VARIANT
		|=> !codeProtected && pmMem_r[0] == PM_BLANK && dmMem_r[0] == DM_BLANK)
		else $error("clear sequence left data or protection");
	a_busy_len: assert property (beginCmd |=> progBusy [*8])
		else $error("busy dropped early");
	c_erase: cover property (beginCmd && seq_r == FCP_SEQ_ARMED);
	c_prot_read: cover property (readPm && prot && inPm);
	c_cfg_write: cover property (beginCmd && isCfg && prot);
endmodule // fcp_config_protect

// ---- bench/fcp_prog_model.sv ----
// behavioural serial programmer on the far side of the program/verify link
`timescale 1ns/10ps
module fcp_prog_model
	import fcp_pkg::*;
#(
	parameter int WAIT_CYC = 24  // programmer's own wait after begin programming
) (
	input  wire logic mclk,        // system clock
	output logic      pgmClk,      // serial clock, stands low between frames
	output logic      pgmDataWire, // resolved data pin level
	input  wire logic pgmDataOut,  // device data value
	input  wire logic pgmDataOe_n  // low while the device drives
);
	logic        progBit;
	logic        progDrv;
	logic        idleBit;
	logic [15:0] rdBits;

	initial begin
		pgmClk = 1'b0;
		progBit = 1'b0;
		progDrv = 1'b1;
		idleBit = 1'b0;
	end

	// a released pin has no pull, so it shows a level that keeps moving
	always @(posedge mclk) begin
		idleBit <= ~idleBit;
	end
	assign pgmDataWire = !pgmDataOe_n ? pgmDataOut : (progDrv ? progBit : idleBit);

	// one bit: data set with the rise, taken at the fall, read just before it
	task automatic bitx(input logic b);
		progBit = b;
		pgmClk = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		rdBits = {pgmDataWire, rdBits[15:1]};
		pgmClk = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
	endtask

	task automatic cmd(input logic [5:0] c);
		for (int i = 0; i < 6; i++) begin
			bitx(c[i]);
		end
	endtask

	// load frame: start bit, fourteen payload bits, stop bit
	task automatic load(input logic [5:0] c, input logic [13:0] w);
		cmd(c);
		bitx(1'b0);
		for (int i = 0; i < 14; i++) begin
			bitx(w[i]);
		end
		bitx(1'b0);
	endtask

	// read frame: the pin is released for all sixteen clocks
	task automatic rd(input logic [5:0] c, output logic [13:0] w);
		cmd(c);
		progDrv = 1'b0;
		for (int i = 0; i < 16; i++) begin
			bitx(1'b0);
		end
		progDrv = 1'b1;
		w = rdBits[14:1];
	endtask

	// the device flags no completion we rely on, so wait out the write time
	task automatic prog();
		cmd(CMD_BEGIN_PROG);
		repeat (WAIT_CYC) @(posedge mclk);
		#1;
	endtask

	task automatic clear_protect();
		load(CMD_LOAD_CFG, 14'h3FFF);
		repeat (7) cmd(CMD_INC_ADDR);
		cmd(CMD_ERASE_A);
		cmd(CMD_ERASE_B);
		prog();
		cmd(CMD_ERASE_A);
		cmd(CMD_ERASE_B);
	endtask
endmodule // fcp_prog_model

// ---- bench/fcp_tb.sv ----
// self-checking bench for the code-protect and configuration block
`timescale 1ns/10ps
module tb;
	import fcp_pkg::*;
	localparam int WAIT_SIM = 20;
	logic        mclk;
	logic        arst_n;
	logic        pgmClk;
	logic        pgmData;
	logic        pgmDataOut;
	logic        pgmDataOe_n;
	logic        codeProtected;
	fcp_cfg_s    cfgWord;
	logic        progBusy;
	logic [13:0] rdw;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;

	fcp_config_protect #(.MASK_VARIANT(1'b0), .PROG_WAIT_CYCLES(WAIT_SIM)) u_dut (
		.mclk(mclk), .arst_n(arst_n), .pgmClk(pgmClk), .pgmDataIn(pgmData),
		.pgmDataOut(pgmDataOut), .pgmDataOe_n(pgmDataOe_n),
		.codeProtected(codeProtected), .cfgWord(cfgWord), .progBusy(progBusy));

	fcp_prog_model #(.WAIT_CYC(WAIT_SIM + 4)) u_prog (
		.mclk(mclk), .pgmClk(pgmClk), .pgmDataWire(pgmData),
		.pgmDataOut(pgmDataOut), .pgmDataOe_n(pgmDataOe_n));

	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// a run needs about 10k cycles; four times that means a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic t_reset();
		chk("cfg", cfgWord, CFG_ERASED);
		chk("prot", {13'h0000, codeProtected}, 14'h0000);
		chk("oe", {13'h0000, pgmDataOe_n}, 14'h0001);
	endtask

	// address is still zero here, so program memory is reachable
	task automatic t_unprot();
		u_prog.load(CMD_LOAD_PM, 14'h2A5C);
		// busy is a level that runs out on its own count
		u_prog.cmd(CMD_BEGIN_PROG);
		chk("busy", {13'h0000, progBusy}, 14'h0001);
		repeat (WAIT_SIM) @(posedge mclk);
		#1;
		chk("idle", {13'h0000, progBusy}, 14'h0000);
		u_prog.rd(CMD_READ_PM, rdw);
		chk("pm0", rdw, 14'h2A5C);
		u_prog.load(CMD_LOAD_DM, 14'h00A5);
		u_prog.prog();
		u_prog.rd(CMD_READ_DM, rdw);
		chk("dm0", {6'h00, rdw[7:0]}, 14'h00A5);
	endtask

	task automatic t_protect();
		u_prog.load(CMD_LOAD_CFG, 14'h0ABC);
		u_prog.prog();
		repeat (7) u_prog.cmd(CMD_INC_ADDR);
		u_prog.load(CMD_LOAD_PM, 14'h000B);
		u_prog.prog();
		chk("cfgw", cfgWord, 14'h000B);
		chk("prot", {13'h0000, codeProtected}, 14'h0001);
		u_prog.rd(CMD_READ_PM, rdw);
		chk("cfgrd", rdw, 14'h000B);
		u_prog.load(CMD_LOAD_PM, 14'h0007);
		u_prog.prog();
		chk("wdt", {13'h0000, cfgWord.watchdogEnableBit}, 14'h0001);
		u_prog.load(CMD_LOAD_CFG, 14'h0001);
		u_prog.prog();
		u_prog.rd(CMD_READ_PM, rdw);
		chk("id0", rdw, 14'h0001);
		u_prog.rd(CMD_READ_DM, rdw);
		chk("dmmask", {6'h00, rdw[7:0]}, 14'h0000);
		// try a data byte at 0x2007 while protected, then lift protection to look
		repeat (7) u_prog.cmd(CMD_INC_ADDR);
		u_prog.load(CMD_LOAD_DM, 14'h005A);
		u_prog.prog();
		u_prog.load(CMD_LOAD_PM, CFG_ERASED);
		u_prog.prog();
		chk("unprot", {13'h0000, codeProtected}, 14'h0000);
		u_prog.rd(CMD_READ_DM, rdw);
		chk("dmblock", {6'h00, rdw[7:0]}, 14'h00FF);
		u_prog.load(CMD_LOAD_PM, 14'h000B);
		u_prog.prog();
		chk("reprot", {13'h0000, codeProtected}, 14'h0001);
	endtask

	task automatic t_clear();
		u_prog.clear_protect();
		chk("cfgclr", cfgWord, CFG_ERASED);
		chk("prot", {13'h0000, codeProtected}, 14'h0000);
		u_prog.load(CMD_LOAD_CFG, 14'h3FFF);
		u_prog.rd(CMD_READ_DM, rdw);
		chk("dmclr", {6'h00, rdw[7:0]}, 14'h00FF);
	endtask

	// every oscillator code, watchdog off, protection left off
	task automatic t_osc();
		repeat (7) u_prog.cmd(CMD_INC_ADDR);
		for (int i = 0; i < 4; i++) begin
			u_prog.load(CMD_LOAD_PM, {10'h3FF, 2'b10, 2'(i)});
			u_prog.prog();
			chk("osc", {12'h000, cfgWord.oscillatorSelectField}, 14'(i));
			chk("wdt", {13'h0000, cfgWord.watchdogEnableBit}, 14'h0000);
		end
		u_prog.rd(CMD_READ_PM, rdw);
		chk("cfgrd", rdw, 14'h3FFB);
	endtask

	initial begin
		arst_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		t_reset();
		repeat (3) @(posedge mclk);
		#1;
		t_unprot();
		t_protect();
		t_clear();
		t_osc();
		finish_test();
	end
endmodule // tb
